//--- hw/seecl_bitio.sv
// two-wire bit engine: start, stop, byte write and byte read
`include "seecl_cfg.svh"
module seecl_bitio (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_op_valid,
    input wire seecl_pkg::seecl_op_t i_op,
    input wire logic [7:0] i_tx_byte,
    input wire logic i_ack_send,
    input wire logic i_sda,
    output logic o_done,
    output logic [7:0] o_rx_byte,
    output logic o_ack_seen,
    output logic o_scl,
    output logic o_sda_oe
);
    seecl_pkg::seecl_bit_st_t q, d;

    always_comb
    begin
        d = q;
        d.done = 1'b0;
        d.sda_s1 = i_sda;
        d.sda_s2 = q.sda_s1;
        // saturate so a long idle high clock cannot wrap to a short count
        if (!q.scl)
            d.hi_run = 11'h000;
        else if (q.hi_run != 11'h7ff)
            d.hi_run = q.hi_run + 11'h001;
        if (!q.busy)
        begin
            if (i_op_valid)
            begin
                d.busy = 1'b1;
                d.op = i_op;
                d.phase = 2'h0;
                d.bitn = 4'h0;
                d.div = 9'h000;
                d.shift = i_tx_byte;
                d.ack_send = i_ack_send;
            end
        end
        else if (q.div != 9'(`SEECL_QTR_CYC - 1))
        begin
            d.div = q.div + 9'h001;
        end
        else
        begin
            d.div = 9'h000;
            d.phase = q.phase + 2'h1;
            unique case (q.phase)
                2'h0:
                begin
                    // data only moves while the clock is low
                    if (q.op == seecl_pkg::OP_START)
                        d.sda_oe = 1'b0;
                    else if (q.op == seecl_pkg::OP_STOP)
                        d.sda_oe = 1'b1;
                    else if (q.bitn == 4'h8)
                        d.sda_oe = (q.op == seecl_pkg::OP_READ) && q.ack_send;
                    else
                        d.sda_oe = (q.op == seecl_pkg::OP_WRITE) && !q.shift[7];
                end
                2'h1:
                    d.scl = 1'b1;
                2'h2:
                begin
                    if (q.op == seecl_pkg::OP_START)
                        d.sda_oe = 1'b1;
                    else if (q.op == seecl_pkg::OP_STOP)
                        d.sda_oe = 1'b0;
                    else if (q.bitn == 4'h8)
                        d.ack_seen = !q.sda_s2;
                    else if (q.op == seecl_pkg::OP_READ)
                        d.shift = {q.shift[6:0], q.sda_s2};
                end
                2'h3:
                begin
                    if (q.op != seecl_pkg::OP_STOP)
                        d.scl = 1'b0;
                    if (q.op == seecl_pkg::OP_WRITE)
                        d.shift = {q.shift[6:0], 1'b0};
                    d.bitn = q.bitn + 4'h1;
                    if (q.op == seecl_pkg::OP_START || q.op == seecl_pkg::OP_STOP || q.bitn == 4'h8)
                    begin
                        d.busy = 1'b0;
                        d.done = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            q <= '0;
            q.scl <= 1'b1;
            q.sda_s1 <= 1'b1;
            q.sda_s2 <= 1'b1;
        end
        else
            q <= d;
    end

    assign o_done = q.done;
    assign o_rx_byte = q.shift;
    assign o_ack_seen = q.ack_seen;
    assign o_scl = q.scl;
    assign o_sda_oe = q.sda_oe;

    sda_stable_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (q.scl && $past(q.scl) && q.sda_oe != $past(q.sda_oe))
        |-> (q.op == seecl_pkg::OP_START || q.op == seecl_pkg::OP_STOP))
        else $error("data line moved while clock high outside start or stop");
    start_cond_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ($fell(q.busy) && q.op == seecl_pkg::OP_START) |-> (q.sda_oe && !q.scl && $past(q.sda_oe, 2)))
        else $error("start did not end with data low");
    stop_cond_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ($fell(q.busy) && q.op == seecl_pkg::OP_STOP) |-> (!q.sda_oe && q.scl))
        else $error("stop did not end with data released and clock high");
    clk_high_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $fell(q.scl) |-> q.hi_run >= 11'(2 * `SEECL_QTR_CYC))
        else $error("serial clock high phase too short");
endmodule

//--- hw/seecl_cfg.svh
// constants of the serial eeprom configuration loader
`ifndef SEECL_CFG_SVH
`define SEECL_CFG_SVH
`define SEECL_CLK_PERIOD_NS 5
`define SEECL_SCL_PERIOD_NS 2500
`define SEECL_QTR_CYC ((`SEECL_SCL_PERIOD_NS + 4 * `SEECL_CLK_PERIOD_NS - 1) / (4 * `SEECL_CLK_PERIOD_NS))
`define SEECL_DIV_W 9
`define SEECL_HI_W 11
`define SEECL_DEV_WR 8'ha0
`define SEECL_DEV_RD 8'ha1
`define SEECL_START_ADDR 8'h00
`define SEECL_SIG 8'h5a
`define SEECL_LAST 3'h6
`define SEECL_ID_RST 16'h0000
`define SEECL_GCFG_RST 16'h0000
`endif

//--- hw/seecl_loader.sv
// power-up serial eeprom configuration loader with host access port
// Overview of operation
// - after reset, probe the eeprom and load ids and two configuration bytes
// - check the signature byte; abandon the load when it mismatches
// - data line moves only while the serial clock is low
// - start and stop are data changes while the serial clock is high
// - dummy write of address zero, repeated start, device address, then read
// - read starts at byte zero and proceeds sequentially byte by byte
// - seven bytes are fetched during a load whose signature matches, two when it mismatches
// - after loading, the host reads and writes the eeprom through this block
// - with no eeprom present, default configuration values stay in place
// - ids read zero unless loaded from eeprom or written by the host
`include "seecl_cfg.svh"
module seecl_loader (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_cfg_serial_data,
    output logic o_cfg_serial_data,
    output logic o_cfg_serial_data_oe,
    output logic o_cfg_serial_clock,
    input wire logic i_host_req,
    input wire seecl_pkg::seecl_host_req_t i_host_cmd,
    output logic o_host_ready,
    output logic o_host_ack,
    output logic o_host_err,
    output logic [7:0] o_host_rdata,
    input wire logic i_host_id_we,
    input wire logic [15:0] i_host_sub_id,
    input wire logic [15:0] i_host_sub_vid,
    output seecl_pkg::seecl_cfg_t o_cfg,
    output logic o_load_done,
    output logic o_eeprom_found
);
    seecl_pkg::seecl_main_st_t q, d;
    logic bit_done;
    logic bit_ack_seen;
    logic [7:0] bit_rx;

    function automatic seecl_pkg::seecl_op_t op_of(input seecl_pkg::seecl_state_t st);
        unique case (st)
            seecl_pkg::ST_START, seecl_pkg::ST_RSTART: op_of = seecl_pkg::OP_START;
            seecl_pkg::ST_READ: op_of = seecl_pkg::OP_READ;
            seecl_pkg::ST_STOP: op_of = seecl_pkg::OP_STOP;
            default: op_of = seecl_pkg::OP_WRITE;
        endcase
    endfunction

    seecl_bitio u_bitio (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_op_valid(q.op_valid),
        .i_op(q.op),
        .i_tx_byte(q.tx),
        .i_ack_send(q.ack_send),
        .i_sda(i_cfg_serial_data),
        .o_done(bit_done),
        .o_rx_byte(bit_rx),
        .o_ack_seen(bit_ack_seen),
        .o_scl(o_cfg_serial_clock),
        .o_sda_oe(o_cfg_serial_data_oe)
    );

    always_comb
    begin
        d = q;
        d.op_valid = 1'b0;
        d.host_ack = 1'b0;
        if (i_host_id_we)
        begin
            d.cfg.sub_id = i_host_sub_id;
            d.cfg.sub_vid = i_host_sub_vid;
            d.hw_seen = 1'b1;
        end
        if (q.st != seecl_pkg::ST_IDLE && !q.wait_op)
        begin
            d.wait_op = 1'b1;
            d.op_valid = 1'b1;
            d.op = op_of(q.st);
            d.ack_send = q.loading && q.cnt != `SEECL_LAST && !q.abort;
            unique case (q.st)
                seecl_pkg::ST_DEVW: d.tx = `SEECL_DEV_WR;
                seecl_pkg::ST_ADDR: d.tx = q.loading ? `SEECL_START_ADDR : q.req.addr;
                seecl_pkg::ST_WDATA: d.tx = q.req.wdata;
                seecl_pkg::ST_DEVR: d.tx = `SEECL_DEV_RD;
                default: d.tx = 8'h00;
            endcase
        end
        else if (q.st != seecl_pkg::ST_IDLE && bit_done)
        begin
            d.wait_op = 1'b0;
            unique case (q.st)
                seecl_pkg::ST_START:
                    d.st = seecl_pkg::ST_DEVW;
                seecl_pkg::ST_DEVW:
                begin
                    d.st = bit_ack_seen ? seecl_pkg::ST_ADDR : seecl_pkg::ST_STOP;
                    d.fail = !bit_ack_seen;
                end
                seecl_pkg::ST_ADDR:
                begin
                    d.fail = !bit_ack_seen;
                    if (!bit_ack_seen)
                        d.st = seecl_pkg::ST_STOP;
                    else if (!q.loading && q.req.write)
                        d.st = seecl_pkg::ST_WDATA;
                    else
                        d.st = seecl_pkg::ST_RSTART;
                end
                seecl_pkg::ST_WDATA:
                begin
                    d.fail = !bit_ack_seen;
                    d.st = seecl_pkg::ST_STOP;
                end
                seecl_pkg::ST_RSTART:
                    d.st = seecl_pkg::ST_DEVR;
                seecl_pkg::ST_DEVR:
                begin
                    d.fail = !bit_ack_seen;
                    d.cnt = 3'h0;
                    d.st = bit_ack_seen ? seecl_pkg::ST_READ : seecl_pkg::ST_STOP;
                end
                seecl_pkg::ST_READ:
                begin
                    d.stage[q.cnt] = bit_rx;
                    d.host_rdata = bit_rx;
                    if (q.loading && q.cnt == 3'h0 && bit_rx != `SEECL_SIG)
                        d.abort = 1'b1;
                    if (q.ack_send)
                        d.cnt = q.cnt + 3'h1;
                    else
                        d.st = seecl_pkg::ST_STOP;
                end
                seecl_pkg::ST_STOP:
                begin
                    if (q.loading)
                    begin
                        if (!q.fail && !q.abort)
                        begin
                            d.cfg.sub_vid = {q.stage[2], q.stage[1]};
                            d.cfg.sub_id = {q.stage[4], q.stage[3]};
                            d.cfg.gen_cfg = {q.stage[6], q.stage[5]};
                        end
                        d.found = !q.fail;
                        d.load_done = 1'b1;
                        d.loading = 1'b0;
                    end
                    else
                    begin
                        d.host_ack = 1'b1;
                        d.host_err = q.fail;
                    end
                    d.fail = 1'b0;
                    d.abort = 1'b0;
                    d.st = seecl_pkg::ST_IDLE;
                end
                default:
                    d.st = seecl_pkg::ST_IDLE;
            endcase
        end
        else if (q.st == seecl_pkg::ST_IDLE && i_host_req)
        begin
            d.req = i_host_cmd;
            d.st = seecl_pkg::ST_START;
        end
        d.ready = d.st == seecl_pkg::ST_IDLE;
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            q <= '0;
            q.st <= seecl_pkg::ST_START;
            q.loading <= 1'b1;
            q.cfg <= {`SEECL_ID_RST, `SEECL_ID_RST, `SEECL_GCFG_RST};
        end
        else
            q <= d;
    end

    assign o_cfg_serial_data = 1'b0;
    assign o_host_ready = q.ready;
    assign o_host_ack = q.host_ack;
    assign o_host_err = q.host_err;
    assign o_host_rdata = q.host_rdata;
    assign o_cfg = q.cfg;
    assign o_load_done = q.load_done;
    assign o_eeprom_found = q.found;

    sig_abort_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (q.st == seecl_pkg::ST_STOP && bit_done && q.loading && q.abort && !i_host_id_we) |=> $stable(q.cfg))
        else $error("configuration changed after bad signature");
    nack_keep_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (q.st == seecl_pkg::ST_STOP && bit_done && q.loading && q.fail && !i_host_id_we)
        |=> ($stable(q.cfg) && q.load_done && !q.found))
        else $error("failed probe altered configuration");
    byte_count_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (q.op_valid && q.op == seecl_pkg::OP_READ && q.loading && !q.abort) |-> (q.ack_send == (q.cnt != 3'h6)))
        else $error("load read count is not seven");
    addr_zero_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (q.op_valid && q.st == seecl_pkg::ST_ADDR && q.loading) |-> (q.tx == 8'h00 && $past(q.st, 1) == q.st))
        else $error("load byte address is not zero");
    rd_addr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (q.op_valid && q.st == seecl_pkg::ST_DEVR) |-> (q.tx == 8'ha1 && q.op == seecl_pkg::OP_WRITE))
        else $error("read address byte wrong");
    host_after_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        q.host_ack |-> (q.load_done && !q.loading && q.ready))
        else $error("host access completed before load finished");
    id_zero_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (!q.found && !q.hw_seen) |-> (q.cfg.sub_id == 16'h0000 && q.cfg.sub_vid == 16'h0000))
        else $error("ids nonzero without load or host write");
    no_dev_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (q.st == seecl_pkg::ST_DEVW && bit_done && !bit_ack_seen && q.loading) |=> q.st == seecl_pkg::ST_STOP ##0 q.fail)
        else $error("missing eeprom not handled");

    load_ok_c: cover property (@(posedge i_clk) disable iff (!i_rst_n) $rose(q.load_done) && q.found && q.hw_seen == 1'b0);
    load_none_c: cover property (@(posedge i_clk) disable iff (!i_rst_n) $rose(q.load_done) && !q.found);
    host_rd_c: cover property (@(posedge i_clk) disable iff (!i_rst_n) q.host_ack && !q.req.write && !q.host_err);
    host_wr_c: cover property (@(posedge i_clk) disable iff (!i_rst_n) q.host_ack && q.req.write);
endmodule

//--- hw/seecl_pkg.sv
// types of the serial eeprom configuration loader
package seecl_pkg;
    typedef enum logic [1:0] {OP_START = 2'h0, OP_WRITE = 2'h1, OP_READ = 2'h3, OP_STOP = 2'h2} seecl_op_t;

    typedef enum logic [3:0] {
        ST_START = 4'h0,
        ST_DEVW = 4'h1,
        ST_ADDR = 4'h3,
        ST_RSTART = 4'h2,
        ST_DEVR = 4'h6,
        ST_READ = 4'h7,
        ST_STOP = 4'h5,
        ST_IDLE = 4'h4,
        ST_WDATA = 4'hc
    } seecl_state_t;

    typedef struct packed {
        logic [15:0] sub_id;
        logic [15:0] sub_vid;
        logic [15:0] gen_cfg;
    } seecl_cfg_t;

    typedef struct packed {
        logic write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } seecl_host_req_t;

    typedef struct packed {
        seecl_op_t op;
        logic busy;
        logic [1:0] phase;
        logic [3:0] bitn;
        logic [8:0] div;
        logic [7:0] shift;
        logic ack_send;
        logic ack_seen;
        logic scl;
        logic sda_oe;
        logic done;
        logic sda_s1;
        logic sda_s2;
        logic [10:0] hi_run;
    } seecl_bit_st_t;

    typedef struct packed {
        seecl_state_t st;
        logic wait_op;
        logic loading;
        logic fail;
        logic abort;
        logic [2:0] cnt;
        logic [6:0][7:0] stage;
        seecl_cfg_t cfg;
        seecl_host_req_t req;
        logic load_done;
        logic found;
        logic hw_seen;
        logic ready;
        logic host_ack;
        logic host_err;
        logic [7:0] host_rdata;
        logic op_valid;
        seecl_op_t op;
        logic [7:0] tx;
        logic ack_send;
    } seecl_main_st_t;
endpackage

//--- verif/seecl_eeprom_model.sv
// behavioural two-wire eeprom that answers the loader
module seecl_eeprom_model (
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_present,
    input wire logic i_bad_sig,
    input wire logic i_rst_n,
    output logic o_sda_low,
    output int o_starts,
    output int o_stops,
    output int o_reads,
    output logic [7:0] o_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [256];
    logic [7:0] sh;
    logic [7:0] cur;
    logic [7:0] ptr;
    logic nack;
    int bitc;
    int st;
    initial
    begin
        for (int i = 0; i < 256; i++)
            mem[i] = 8'hff;
        mem[0] = 8'h5a;
        mem[1] = 8'h34;
        mem[2] = 8'h12;
        mem[3] = 8'h78;
        mem[4] = 8'h56;
        mem[5] = 8'hcd;
        mem[6] = 8'hab;
        o_sda_low = 1'b0;
        st = 0;
        bitc = 0;
        ptr = 8'h00;
        o_addr = 8'hff;
    end
    always @(negedge i_rst_n)
    begin
        o_starts = 0;
        o_stops = 0;
        o_reads = 0;
        o_addr = 8'hff;
    end
    // start and stop seen as data moves while clock is high
    always @(negedge i_sda)
        if (i_scl === 1'b1)
        begin
            o_starts++;
            st = 1;
            bitc = 0;
            o_sda_low = 1'b0;
        end
    always @(posedge i_sda)
        if (i_scl === 1'b1)
        begin
            o_stops++;
            st = 0;
            o_sda_low = 1'b0;
        end
    always @(posedge i_scl)
        if (st != 0)
        begin
            if (bitc < 8)
                sh = {sh[6:0], i_sda};
            bitc++;
            if (bitc == 9)
                nack = i_sda;
        end
    // own data moves only while the clock is low
    always @(negedge i_scl)
        if (st != 0)
        begin
            if (bitc == 8)
            begin
                if (st == 4)
                begin
                    o_sda_low = 1'b0;
                    ptr++;
                end
                else if (st == 1 && !(i_present && sh[7:1] == 7'h50))
                    st = 0;
                else
                begin
                    o_sda_low = 1'b1;
                    if (st == 2)
                    begin
                        ptr = sh;
                        o_addr = sh;
                    end
                    if (st == 3)
                    begin
                        mem[ptr] = sh;
                        ptr++;
                    end
                end
            end
            else if (bitc == 9)
            begin
                o_sda_low = 1'b0;
                bitc = 0;
                if (st == 1)
                    st = sh[0] ? 4 : 2;
                else if (st == 2)
                    st = 3;
                else if (st == 4 && nack)
                    st = 0;
                if (st == 4)
                begin
                    cur = (ptr == 8'h00 && i_bad_sig) ? 8'ha5 : mem[ptr];
                    o_sda_low = !cur[7];
                    o_reads++;
                end
            end
            else if (st == 4)
                o_sda_low = !cur[7 - bitc];
        end
endmodule

//--- verif/seecl_loader_tb.sv
// self-checking bench of the serial eeprom configuration loader
module seecl_loader_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic host_req = 1'b0;
    seecl_pkg::seecl_host_req_t host_cmd = '0;
    logic id_we = 1'b0;
    logic [15:0] sub_id = 16'h0000;
    logic [15:0] sub_vid = 16'h0000;
    logic present = 1'b1;
    logic bad_sig = 1'b0;
    logic sda_w, sda_oe, scl, mdl_low, host_ready, host_ack, host_err, load_done, found;
    logic [7:0] host_rdata;
    logic sda_o;
    logic [7:0] addr_set;
    seecl_pkg::seecl_cfg_t cfg;
    int starts, stops, reads;
    int n_errors = 0;
    int check_count = 0;
    always #2.5 clk = ~clk;
    // pull-up: wire low when either side pulls
    assign sda_w = (sda_oe === 1'b1 || mdl_low === 1'b1) ? 1'b0 : 1'b1;
    seecl_loader uut (.i_clk(clk), .i_rst_n(rst_n), .i_cfg_serial_data(sda_w), .o_cfg_serial_data(sda_o),
        .o_cfg_serial_data_oe(sda_oe), .o_cfg_serial_clock(scl), .i_host_req(host_req),
        .i_host_cmd(host_cmd), .o_host_ready(host_ready), .o_host_ack(host_ack), .o_host_err(host_err),
        .o_host_rdata(host_rdata), .i_host_id_we(id_we), .i_host_sub_id(sub_id), .i_host_sub_vid(sub_vid),
        .o_cfg(cfg), .o_load_done(load_done), .o_eeprom_found(found));
    seecl_eeprom_model mdl (.i_scl(scl), .i_sda(sda_w), .i_present(present), .i_bad_sig(bad_sig),
        .i_rst_n(rst_n), .o_sda_low(mdl_low), .o_starts(starts), .o_stops(stops), .o_reads(reads),
        .o_addr(addr_set));
    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic do_reset(input logic p, input logic b);
        @(posedge clk);
        rst_n <= 1'b0;
        present <= p;
        bad_sig <= b;
        repeat (20) @(posedge clk);
        check(cfg, 48'h0, "cfg in reset");
        check({scl, sda_oe}, 2'b10, "link idle in reset");
        check(sda_o, 1'b0, "open drain value");
        rst_n <= 1'b1;
    endtask
    task automatic wait_load;
        int n;
        n = 0;
        while (load_done !== 1'b1 && n < 60000)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        check(load_done, 1'b1, "load finished");
        check({scl, sda_oe}, 2'b10, "link released");
    endtask
    task automatic host_xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        check(host_ready, 1'b1, "host port ready");
        @(posedge clk);
        host_req <= 1'b1;
        host_cmd <= '{w, a, d};
        @(posedge clk);
        host_req <= 1'b0;
        while (host_ack !== 1'b1 && n < 30000)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        check(host_ack, 1'b1, "host transfer done");
    endtask
    task automatic t_good_load;
        realtime t0;
        do_reset(1'b1, 1'b0);
        repeat (3) @(posedge scl);
        t0 = $realtime;
        @(posedge scl);
        check(64'(longint'($realtime - t0)), 64'd2500, "serial clock period");
        wait_load();
        check(found, 1'b1, "eeprom found");
        check(cfg, {16'h5678, 16'h1234, 16'habcd}, "loaded cfg");
        check(starts, 2, "start count");
        check(stops, 1, "stop count");
        check(addr_set, 8'h00, "start address");
        check(reads, 7, "bytes fetched");
    endtask
    task automatic t_host_rw;
        host_xfer(1'b1, 8'h10, 8'h3c);
        check(host_err, 1'b0, "write acknowledged");
        host_xfer(1'b0, 8'h10, 8'h00);
        check(host_err, 1'b0, "read acknowledged");
        check(host_rdata, 8'h3c, "read back");
    endtask
    task automatic t_id_write;
        @(posedge clk);
        id_we <= 1'b1;
        sub_id <= 16'hbeef;
        sub_vid <= 16'hcafe;
        @(posedge clk);
        id_we <= 1'b0;
        #1;
        check(cfg, {16'hbeef, 16'hcafe, 16'habcd}, "host id write");
    endtask
    task automatic t_bad_sig;
        do_reset(1'b1, 1'b1);
        wait_load();
        check(cfg, 48'h0, "cfg after bad header");
        check(reads, 2, "reads after bad header");
        check(stops, 1, "stop after bad header");
    endtask
    task automatic t_absent;
        do_reset(1'b0, 1'b0);
        wait_load();
        check(found, 1'b0, "nothing found");
        check(cfg, 48'h0, "defaults kept");
        check(starts, 1, "single attempt");
        host_xfer(1'b0, 8'h00, 8'h00);
        check(host_err, 1'b1, "host read unanswered");
    endtask
    initial
    begin
        #700000;
        n_errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        report_and_stop();
    end
    initial
    begin
        t_good_load();
        t_host_rw();
        t_id_write();
        t_bad_sig();
        t_absent();
        report_and_stop();
    end
endmodule
